// ==== serial_comm_unit.sv ====
// Purpose: Serial communication unit with mode, format and clock selection.
// Assumes: rxd and sckIn are synchronous to ref_clk; Wishbone classic slave.
// Notes:   Ack comes one cycle after the request; registers are eight bits wide, receive data nine.
//
// Notes on behaviour
// - Mode bit 7 selects async or synchronous.
// - Bit 6: eight or seven async data bits.
// - Bit 3: one or two stop bits.
// - Parity if enabled; multiprocessor bit replaces it.
// - Async receive flags framing, parity, overrun, break.
// - Sync: eight bits, no parity or stops.
// - Sync receive reports only overrun.
// - Async internal clock; pin unused or bit-rate output.
// - Async external: pin input at sixteen times rate.
// - Internal clock comes from the rate generator.
// - Sync internal drives serial clock on pin.
// - Sync external shifts on pin clock, generator bypassed.
// - Prescaler divides by 1, 4, 16, 64.
// - Eight-bit divisor sets the bit rate.
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
module serial_comm_unit
	import serial_mode_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        rxd,			// Receive line.
	output logic             txd,			// Transmit line.
	input  wire logic        sckIn,			// Clock pin level.
	output logic             sckOut,		// Clock pin drive value.
	output logic             sckOe,			// Clock pin drive enable.
	output logic             irq			// Level interrupt.
);
	import serial_mode_pkg::*;
	// ================================================================
	// Registers.
	logic [7:0] serialModeReg;			// Mode and format selection.
	logic [7:0] serialControlReg;			// Enables and clock selection.
	logic [7:0] bitRateDivisor;			// Divisor N.
	logic [7:0] txData;				// Byte awaiting transmission.
	logic       txPending;				// txData not yet loaded.
	logic [8:0] rxData;				// Last received byte and MPB.
	logic [7:0] status;				// Sticky events.
	logic [7:0] intMask;				// Interrupt mask.
	logic [7:0] statusSet;				// Events raised this cycle.

	// ================================================================
	// Bus decode.
	wire busReq   = wb_cyc_i && wb_stb_i;
	wire busWrite = busReq && wb_ack_o && wb_we_i && wb_sel_i[0];
	wire wrMode   = busWrite && (wb_adr_i == MODE_OFFSET);
	wire wrCtrl   = busWrite && (wb_adr_i == CONTROL_OFFSET);
	wire wrDiv    = busWrite && (wb_adr_i == DIVISOR_OFFSET);
	wire wrTx     = busWrite && (wb_adr_i == TXDATA_OFFSET);
	wire wrStatus = busWrite && (wb_adr_i == STATUS_OFFSET);
	wire wrMask   = busWrite && (wb_adr_i == MASK_OFFSET);
	logic [31:0] readMux;				// Unmapped offsets read zero.

	always_comb begin
		case (wb_adr_i)
			MODE_OFFSET:    readMux = {24'h000000, serialModeReg};
			CONTROL_OFFSET: readMux = {24'h000000, serialControlReg};
			DIVISOR_OFFSET: readMux = {24'h000000, bitRateDivisor};
			TXDATA_OFFSET:  readMux = {24'h000000, txData};
			RXDATA_OFFSET:  readMux = {23'h000000, rxData};
			STATUS_OFFSET:  readMux = {24'h000000, status};
			MASK_OFFSET:    readMux = {24'h000000, intMask};
			default:        readMux = 32'h00000000;
		endcase
	end

	// ================================================================
	// Field decode.
	wire syncMode   = serialModeReg[SYNC_MODE_BIT];
	wire extClock   = serialControlReg[EXT_CLOCK_BIT];
	wire clockOutEn = serialControlReg[CLOCK_OUT_BIT];
	wire txEnable   = serialControlReg[TX_ENABLE_BIT];
	wire rxEnable   = serialControlReg[RX_ENABLE_BIT];
	wire mpFormat   = !syncMode && serialModeReg[MULTIPROC_BIT];
	wire parityOn   = !syncMode && !mpFormat && serialModeReg[PARITY_EN_BIT];
	wire extraOn    = parityOn || mpFormat;
	wire twoStop    = !syncMode && serialModeReg[TWO_STOP_BIT];
	wire [3:0] dataLen = (!syncMode && serialModeReg[CHAR_LENGTH_BIT])
		? SHORT_CHAR : LONG_CHAR;
	wire [7:0] dataMask = (dataLen == SHORT_CHAR) ? 8'h7f : 8'hff;
	wire txParity   = (^(txData & dataMask)) ^ serialModeReg[ODD_PARITY_BIT];
	wire txExtra    = mpFormat ? serialControlReg[TX_MPB_BIT] : txParity;
	wire [3:0] frameBits = 4'h1 + dataLen + {3'h0, extraOn} + (twoStop ? 4'h2 : 4'h1);

	// ================================================================
	// Clock selection. The pin is treated as synchronous, so a plain
	// previous-value register is enough to find its edges.
	logic       sckPrev;
	logic       genTick;				// Internal sixteen-times tick.
	logic [3:0] baudPhase;				// Position within an async bit.
	logic       syncActive;			// Synchronous transfer running.
	logic       syncClk;			// Internal synchronous serial clock.
	wire sckRise = sckIn && !sckPrev;
	wire sckFall = !sckIn && sckPrev;
	wire tick16  = extClock ? sckRise : genTick;
	wire bitEdge = !syncMode && tick16 && (baudPhase == OVERSAMPLE_LAST);
	wire syncToggle = syncActive && genTick;
	wire syncRise = extClock ? sckRise : (syncToggle && !syncClk);
	wire syncFall = extClock ? sckFall : (syncToggle && syncClk);

	serial_rate_gen rateGen (
		.ref_clk        (ref_clk),
		.reset_n        (reset_n),
		.enable         (!extClock),
		.prescaleSelect ({serialModeReg[PRESCALE_HI_BIT], serialModeReg[PRESCALE_LO_BIT]}),
		.divisor        (bitRateDivisor),
		.tick           (genTick)
	);

	// Pin drive: async internal only on request, sync internal always.
	assign sckOe  = !extClock && (syncMode || clockOutEn);
	assign sckOut = syncMode ? syncClk : baudPhase[3];

	// ================================================================
	// Transmitter.
	logic [11:0] txShift;				// Frame, line bit in position 0.
	logic [3:0]  txLeft;				// Bits still to send.
	logic [11:0] txFrame;				// Assembled async frame.
	wire asyncLoad = !syncMode && txEnable && txPending && (txLeft == 4'h0) && bitEdge;
	wire syncStart = syncMode && !syncActive && ((txEnable && txPending) || (rxEnable && !txEnable));
	wire txLoad    = asyncLoad || (syncStart && txEnable);

	// Start bit, data LSB first, parity or MPB, then stop bits.
	always_comb begin
		txFrame    = 12'hffe;
		txFrame[8] = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(dataLen)) begin
				txFrame[i + 1] = txData[i];
			end
		end
		if (extraOn) begin
			txFrame[dataLen + 4'h1] = txExtra;
		end
	end

	// Async frames shift on bit boundaries; sync bytes on falling edges.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			txShift <= 12'hfff;
			txLeft  <= 4'h0;
		end else if (asyncLoad) begin
			txShift <= txFrame;
			txLeft  <= frameBits;
		end else if (syncStart && txEnable) begin
			txShift <= {4'hf, txData};
			txLeft  <= SYNC_BITS;
		end else if (!syncMode && bitEdge && txLeft != 4'h0) begin
			txShift <= {1'b1, txShift[11:1]};
			txLeft  <= txLeft - 4'h1;
		end else if (syncMode && syncFall && txLeft != 4'h0 && syncCount != 4'h0) begin
			// The first falling edge leaves bit 0 in place for the first rising edge.
			txShift <= {1'b1, txShift[11:1]};
			txLeft  <= txLeft - 4'h1;
		end
	end
	assign txd = (txLeft != 4'h0) ? txShift[0] : 1'b1;

	// ================================================================
	// Receiver.
	rx_state_type rxState;
	logic [3:0]   rxSub;				// Ticks within the current bit.
	logic [3:0]   rxCount;				// Bits captured so far.
	logic [9:0]   rxBits;				// Captured data, extra bit, stop.
	logic         rxArmed;				// Line seen idle high.
	logic [3:0]   syncCount;			// Sync bits received.
	wire [3:0]    rxLast = dataLen + {3'h0, extraOn};
	wire [7:0]    rxByte = rxBits[7:0] & dataMask;
	wire          rxExtra = rxBits[rxLast - 4'h1];
	wire          rxStop  = rxBits[rxLast];				// Only the first stop is checked.
	wire          rxRxOk  = !syncMode && rxEnable;
	wire          asyncDone = (rxState == RX_CHECK) && !syncMode;
	wire          syncRxDone = syncMode && rxEnable && syncActive && syncRise
		&& (syncCount == SYNC_BITS - 4'h1);
	wire          framingErr = asyncDone && !rxStop;
	wire          parityErr  = asyncDone && parityOn
		&& ((^rxByte ^ rxExtra) != serialModeReg[ODD_PARITY_BIT]);
	wire          breakSeen  = framingErr && (rxByte == 8'h00) && !(extraOn && rxExtra);

	// Async receive: start edge, centre check, then bits every sixteen ticks.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rxState <= RX_IDLE;
			rxSub   <= 4'h0;
			rxCount <= 4'h0;
			rxBits  <= 10'h000;
			rxArmed <= 1'b0;
		end else begin
			case (rxState)
				RX_IDLE: begin
					if (tick16) begin
						rxArmed <= rxd;
					end
					if (rxRxOk && tick16 && rxArmed && !rxd) begin
						rxState <= RX_START;
						rxSub   <= 4'h0;
					end
				end
				RX_START: begin
					if (tick16) begin
						rxSub <= rxSub + 4'h1;
						if (rxSub == SAMPLE_POINT) begin
							rxState <= rxd ? RX_IDLE : RX_DATA;	// Glitch rejected.
							rxSub   <= 4'h0;
							rxCount <= 4'h0;
						end
					end
				end
				RX_DATA: begin
					if (tick16) begin
						rxSub <= rxSub + 4'h1;
						if (rxSub == OVERSAMPLE_LAST) begin
							rxBits[rxCount] <= rxd;
							rxCount         <= rxCount + 4'h1;
							if (rxCount == rxLast) begin
								rxState <= RX_CHECK;
							end
						end
					end
				end
				RX_CHECK: begin
					rxState <= RX_IDLE;
					rxArmed <= 1'b0;
				end
				default: rxState <= RX_IDLE;
			endcase
			if (syncMode) begin
				rxState <= RX_IDLE;
			end
			if (syncMode && syncRise) begin
				rxBits <= {2'h0, rxd, rxBits[7:1]};
			end
		end
	end

	// Synchronous framing: eight rising edges, then the last falling edge.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			syncActive <= 1'b0;
			syncCount  <= 4'h0;
			syncClk    <= 1'b1;
		end else if (syncStart) begin
			syncActive <= 1'b1;
			syncCount  <= 4'h0;
		end else if (syncActive) begin
			if (syncRise) begin
				syncCount <= syncCount + 4'h1;
			end
			if (syncFall && syncCount == SYNC_BITS) begin
				syncActive <= 1'b0;			// Clock parks high, no ninth pulse.
			end else begin
				syncClk <= syncToggle ? !syncClk : syncClk;
			end
		end else begin
			syncClk <= 1'b1;
		end
	end

	// ================================================================
	// Async phase, edge history and received data.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			baudPhase <= 4'h0;
			sckPrev   <= 1'b1;				// Idle pin level, so no false edge.
			rxData    <= 9'h000;
		end else begin
			baudPhase <= tick16 ? baudPhase + 4'h1 : baudPhase;
			sckPrev   <= sckIn;
			if (asyncDone && !status[RX_FULL_BIT]) begin
				rxData <= {mpFormat && rxExtra, rxByte};
			end else if (syncRxDone && !status[RX_FULL_BIT]) begin
				rxData <= {1'b0, rxd, rxBits[7:1]};
			end
		end
	end

	// Event collection; overrun means the previous byte was not cleared.
	always_comb begin
		statusSet                 = 8'h00;
		statusSet[RX_FULL_BIT]    = (asyncDone || syncRxDone) && !status[RX_FULL_BIT];
		statusSet[OVERRUN_BIT]    = (asyncDone || syncRxDone) && status[RX_FULL_BIT];
		statusSet[FRAMING_BIT]    = framingErr && !status[RX_FULL_BIT];
		statusSet[PARITY_ERR_BIT] = parityErr && !status[RX_FULL_BIT];
		statusSet[BREAK_BIT]      = breakSeen;
		statusSet[TX_DONE_BIT]    = (!syncMode && bitEdge && txLeft == 4'h1)
			|| (syncMode && syncFall && syncActive && syncCount == SYNC_BITS && txEnable);
	end

	// ================================================================
	// Register writes. A new event wins over a simultaneous clear.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			serialModeReg    <= MODE_RESET;
			serialControlReg <= CONTROL_RESET;
			bitRateDivisor   <= DIVISOR_RESET;
			txData           <= 8'h00;
			txPending        <= 1'b0;
			status           <= STATUS_RESET;
			intMask          <= MASK_RESET;
		end else begin
			serialModeReg    <= wrMode ? wb_dat_i[7:0] : serialModeReg;
			serialControlReg <= wrCtrl ? wb_dat_i[7:0] : serialControlReg;
			bitRateDivisor   <= wrDiv ? wb_dat_i[7:0] : bitRateDivisor;
			txData           <= wrTx ? wb_dat_i[7:0] : txData;
			txPending        <= wrTx || (txPending && !txLoad);
			intMask          <= wrMask ? wb_dat_i[7:0] : intMask;
			status           <= (status & ~(wrStatus ? wb_dat_i[7:0] : 8'h00)) | statusSet;
		end
	end

	// Bus answer one cycle after the request, dropped the cycle after.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= busReq && !wb_ack_o;
			wb_dat_o <= (busReq && !wb_ack_o) ? readMux : wb_dat_o;
		end
	end
	assign irq = |(status & intMask);

	// ================================================================
	// Checks.
	property p_syncFormat;
		@(posedge ref_clk) disable iff (!reset_n)
		syncMode |-> dataLen == 4'h8 && !extraOn && !twoStop;
	endproperty
	a_syncFormat: assert property (p_syncFormat) else $error("Sync format not fixed");
	property p_shortChar;
		@(posedge ref_clk) disable iff (!reset_n)
		!syncMode && serialModeReg[CHAR_LENGTH_BIT] |-> dataLen == 4'h7;
	endproperty
	a_shortChar: assert property (p_shortChar) else $error("Seven-bit length wrong");
	property p_frameLength;
		@(posedge ref_clk) disable iff (!reset_n)
		asyncLoad |=> txLeft == 4'h1 + $past(dataLen) + {3'h0, $past(extraOn)}
			+ ($past(twoStop) ? 4'h2 : 4'h1) && !txd;
	endproperty
	a_frameLength: assert property (p_frameLength) else $error("Async frame length wrong");
	property p_mpNoParity;
		@(posedge ref_clk) disable iff (!reset_n)
		serialModeReg[MULTIPROC_BIT] |-> !parityOn;
	endproperty
	a_mpNoParity: assert property (p_mpNoParity) else $error("Parity with MP format");
	property p_pinDrive;
		@(posedge ref_clk) disable iff (!reset_n)
		sckOe == (!extClock && (syncMode || clockOutEn));
	endproperty
	a_pinDrive: assert property (p_pinDrive) else $error("Clock pin direction wrong");
	property p_extBypass;
		@(posedge ref_clk) disable iff (!reset_n)
		extClock |-> ##2 !genTick;
	endproperty
	a_extBypass: assert property (p_extBypass) else $error("Generator ran on ext clock");
	property p_overrun;
		@(posedge ref_clk) disable iff (!reset_n)
		(asyncDone || syncRxDone) && status[RX_FULL_BIT] |=> status[OVERRUN_BIT]
			&& $stable(rxData);
	endproperty
	a_overrun: assert property (p_overrun) else $error("Overrun not reported");
	property p_syncErrors;
		@(posedge ref_clk) disable iff (!reset_n)
		syncMode |-> !statusSet[FRAMING_BIT] && !statusSet[PARITY_ERR_BIT]
			&& !statusSet[BREAK_BIT];
	endproperty
	a_syncErrors: assert property (p_syncErrors) else $error("Sync reported async error");
	property p_internalTick;
		@(posedge ref_clk) disable iff (!reset_n)
		!extClock && genTick && !syncMode |-> tick16 ##1 baudPhase == $past(baudPhase) + 4'h1;
	endproperty
	a_internalTick: assert property (p_internalTick) else $error("Internal tick lost");
endmodule : serial_comm_unit

// ==== serial_mode_pkg.sv ====
// Purpose: Shared constants and types for the serial communication unit.
// Assumes: 40 MHz ref_clk, Wishbone registers on aligned 32-bit words.
// Notes:   Registers hold eight significant bits, receive data nine; upper bits read as zero.
package serial_mode_pkg;
	// ================================================================
	// Register map (byte addresses).
	localparam logic [4:0] MODE_OFFSET     = 5'h00;	// serial_mode_reg.
	localparam logic [4:0] CONTROL_OFFSET  = 5'h04;	// serial_control_reg.
	localparam logic [4:0] DIVISOR_OFFSET  = 5'h08;	// bit_rate_divisor.
	localparam logic [4:0] TXDATA_OFFSET   = 5'h0c;	// Transmit data.
	localparam logic [4:0] RXDATA_OFFSET   = 5'h10;	// Receive data, bit 8 is received MPB.
	localparam logic [4:0] STATUS_OFFSET   = 5'h14;	// Sticky events, write one to clear.
	localparam logic [4:0] MASK_OFFSET     = 5'h18;	// Interrupt mask.
	// ================================================================
	// Mode register fields.
	localparam int SYNC_MODE_BIT   = 7;
	localparam int CHAR_LENGTH_BIT = 6;
	localparam int PARITY_EN_BIT   = 5;
	localparam int ODD_PARITY_BIT  = 4;
	localparam int TWO_STOP_BIT    = 3;
	localparam int MULTIPROC_BIT   = 2;
	localparam int PRESCALE_HI_BIT = 1;
	localparam int PRESCALE_LO_BIT = 0;
	// ================================================================
	// Control register fields.
	localparam int TX_ENABLE_BIT   = 5;
	localparam int RX_ENABLE_BIT   = 4;
	localparam int TX_MPB_BIT      = 2;
	localparam int EXT_CLOCK_BIT   = 1;
	localparam int CLOCK_OUT_BIT   = 0;
	// ================================================================
	// Status and mask fields.
	localparam int RX_FULL_BIT     = 0;
	localparam int TX_DONE_BIT     = 1;
	localparam int OVERRUN_BIT     = 2;
	localparam int FRAMING_BIT     = 3;
	localparam int PARITY_ERR_BIT  = 4;
	localparam int BREAK_BIT       = 5;
	// ================================================================
	// Reset values.
	localparam logic [7:0] MODE_RESET    = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] DIVISOR_RESET = 8'hff;
	localparam logic [7:0] STATUS_RESET  = 8'h00;
	localparam logic [7:0] MASK_RESET    = 8'h00;
	// ================================================================
	// Counts.
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;	// Sixteen ticks per async bit.
	localparam logic [3:0] SAMPLE_POINT    = 4'h7;	// Eighth tick is the bit centre.
	localparam logic [3:0] SYNC_BITS       = 4'h8;	// Fixed synchronous data length.
	localparam logic [3:0] LONG_CHAR       = 4'h8;
	localparam logic [3:0] SHORT_CHAR      = 4'h7;
	// Prescaler terminal counts for divide by 1, 4, 16 and 64.
	localparam logic [5:0] PRESCALE_DIV1   = 6'h00;
	localparam logic [5:0] PRESCALE_DIV4   = 6'h03;
	localparam logic [5:0] PRESCALE_DIV16  = 6'h0f;
	localparam logic [5:0] PRESCALE_DIV64  = 6'h3f;
	// ================================================================
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_CHECK} rx_state_type;
endpackage : serial_mode_pkg

// ==== serial_rate_gen.sv ====
// Purpose: Bit rate generator, one tick per sixteenth of an async bit.
// Assumes: Divisor and prescaler change only while the unit is idle.
// Notes:   Tick period is 2 * 4^n * (N+1) reference clocks.
`timescale 1ns/100ps
module serial_rate_gen
	import serial_mode_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       enable,			// Low while an external clock is used.
	input  wire logic [1:0] prescaleSelect,		// Prescaler code n.
	input  wire logic [7:0] divisor,		// Divisor N.
	output logic            tick			// One-cycle pulse.
);
	// ================================================================
	// Prescaler and divider.
	logic [5:0] preCount;				// Prescaler phase.
	logic [7:0] divCount;				// Divider phase.
	logic       half;				// Alternates every N+1 prescaled pulses.
	logic [5:0] preLast;				// Selected terminal count.
	wire        preTick = (preCount == preLast);
	wire        divWrap = preTick && (divCount == divisor);

	// Prescaler terminal count from the code.
	always_comb begin
		case (prescaleSelect)
			2'h0:    preLast = PRESCALE_DIV1;
			2'h1:    preLast = PRESCALE_DIV4;
			2'h2:    preLast = PRESCALE_DIV16;
			default: preLast = PRESCALE_DIV64;
		endcase
	end

	// Counters clear to zero while bypassed, so restart is clean.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			preCount <= 6'h00;
			divCount <= 8'h00;
			half     <= 1'b0;
			tick     <= 1'b0;
		end else if (!enable) begin
			preCount <= 6'h00;
			divCount <= 8'h00;
			half     <= 1'b0;
			tick     <= 1'b0;
		end else begin
			preCount <= preTick ? 6'h00 : preCount + 6'h01;
			divCount <= divWrap ? 8'h00 : (preTick ? divCount + 8'h01 : divCount);
			half     <= divWrap ? !half : half;
			tick     <= divWrap && half;
		end
	end

	// With n=0 and N=0 a tick appears every second clock. The setting must
	// hold over the window, since a rate change restarts the spacing.
	property p_fastestRate;
		@(posedge ref_clk) disable iff (!reset_n)
		tick && enable && prescaleSelect == 2'h0 && divisor == 8'h00
			##1 enable && prescaleSelect == 2'h0 && divisor == 8'h00 |-> !tick ##1 tick;
	endproperty
	a_fastestRate: assert property (p_fastestRate) else $error("Rate tick spacing wrong");
endmodule : serial_rate_gen

// ==== serial_peer.sv ====
// Purpose: Remote serial device on the receive line and the clock pin.
// Assumes: Async bits last 32 reference clocks.
// Notes:   The bench sends frames through sendFrame.
`timescale 1ns/100ps
module serial_peer (
	input  wire logic ref_clk,
	input  wire logic sckOut,
	input  wire logic sckOe,
	output logic      rxd,
	output logic      sckIn
);
	// ==============================
	// Pin clock and line state.
	logic extRun = 1'b0;	// Set while the peer clocks the pin.
	logic extClk = 1'b1;	// Stands high when idle, as if pulled up.
	initial rxd = 1'b1;	// Mark state until a frame is sent.
	// The pin shows the unit's drive when enabled, else the peer's clock.
	assign sckIn = sckOe ? sckOut : extClk;
	// Toggling each clock gives sixteen pin periods per 32-clock bit.
	always @(posedge ref_clk) begin
		if (extRun) begin
			extClk <= ~extClk;
		end
	end
	// Sends n bits LSB first, one bit time each.
	task automatic sendFrame(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			rxd <= bits[i];
			repeat (32) @(posedge ref_clk);
		end
		rxd <= 1'b1;	// Back to mark for one clock, so calls never collide.
		@(posedge ref_clk);
	endtask : sendFrame
endmodule : serial_peer

// ==== tb_top.sv ====
// Purpose: Bench for mode, format and clock selection.
// Assumes: Divisor 0 with prescaler 0 gives a 32-clock async bit.
// Notes:   Every wait is bounded; a timeout counts as a mismatch.
`timescale 1ns/100ps
module tb_top;
	import serial_mode_pkg::*;
	// ==============================
	// Stimulus and observed signals.
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        cyc = 1'b0;	// Also drives the strobe.
	logic        we = 1'b0;
	logic [4:0]  adr = 5'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [15:0] q;		// Last read value.
	logic        ack, rxd, txd, sckIn, sckOut, sckOe, irq;
	int          failCount = 0;
	int          nTests = 0;
	int          c, d;
	logic [4:0]  offs [6] = '{MODE_OFFSET, CONTROL_OFFSET, DIVISOR_OFFSET,
		STATUS_OFFSET, MASK_OFFSET, 5'h1c};
	logic [7:0]  resv [6] = '{MODE_RESET, CONTROL_RESET, DIVISOR_RESET,
		STATUS_RESET, MASK_RESET, 8'h00};
	always #12.5 ref_clk = ~ref_clk;
	serial_comm_unit i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .rxd(rxd), .txd(txd), .sckIn(sckIn),
		.sckOut(sckOut), .sckOe(sckOe), .irq(irq));
	serial_peer i_peer (.ref_clk(ref_clk), .sckOut(sckOut), .sckOe(sckOe), .rxd(rxd),
		.sckIn(sckIn));
	// ==============================
	// Tasks.
	task automatic tallyAndFinish();
		$display("checks %0d mismatches %0d", nTests, failCount);
		if (failCount == 0 && nTests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : tallyAndFinish
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		nTests++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", s, e, g);
			failCount++;
		end
	endtask : chk
	// Holds the request until ack is sampled; a slow answer ends the run.
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
		int k;
		k = 0;
		@(posedge ref_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, v};
		do begin
			@(posedge ref_clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rdat[15:0];
		cyc <= 1'b0;
		we <= 1'b0;
		if (k == 20) begin
			failCount++;
			tallyAndFinish();
		end
	endtask : bus
	// Waits for txd (s high) or sckOut to reach v; n counts the edges.
	task automatic waitPin(input logic s, input logic v, output int n);
		for (n = 0; n < 5000 && (s ? txd : sckOut) !== v; n++) @(posedge ref_clk);
		if (n == 5000) begin
			failCount++;
			tallyAndFinish();
		end
	endtask : waitPin
	// Sends one async byte and checks every bit centre against the format.
	task automatic txFrame(input logic [7:0] m, input logic [7:0] ctl, input logic [7:0] v);
		logic [11:0] b;
		int n;
		b = {4'hf, v} << 1;
		if (m[6]) b[8] = 1'b1;
		n = m[6] ? 8 : 9;
		if (m[2] | m[5]) b[n] = m[2] ? ctl[2] : ^(v & (m[6] ? 8'h7f : 8'hff)) ^ m[4];
		n = n + 1 + (m[2] | m[5]) + m[3];
		i_peer.extRun <= ctl[1];
		bus(1'b1, MODE_OFFSET, m);
		bus(1'b1, CONTROL_OFFSET, ctl);
		bus(1'b1, TXDATA_OFFSET, v);
		waitPin(1'b1, 1'b0, c);
		repeat (16) @(posedge ref_clk);
		for (int i = 0; i < n; i++) begin
			chk("txd", {15'h0, b[i]}, {15'h0, txd});
			repeat (32) @(posedge ref_clk);
		end
	endtask : txFrame
	// ==============================
	// Main sequence.
	initial begin
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		chk("pin enable", 16'h0, {15'h0, sckOe});
		bus(1'b1, 5'h1c, 8'h5a);
		foreach (offs[i]) begin
			bus(1'b0, offs[i], 8'h00);
			chk("reset value", {8'h0, resv[i]}, q);
		end
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, MODE_OFFSET, {i[2], 7'h00});
			bus(1'b1, CONTROL_OFFSET, {6'h00, i[1:0]});
			@(negedge ref_clk);
			chk("sckOe", {15'h0, i[2] ? ~i[1] : ~i[1] & i[0]}, {15'h0, sckOe});
		end
		// Clock-out period is 32 * 4^n * (N+1) clocks.
		bus(1'b1, CONTROL_OFFSET, 8'h01);
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, MODE_OFFSET, {6'h00, i[1:0]});
			bus(1'b1, DIVISOR_OFFSET, i == 4 ? 8'h02 : 8'h00);
			waitPin(1'b0, 1'b0, c);
			waitPin(1'b0, 1'b1, c);
			waitPin(1'b0, 1'b0, c);
			waitPin(1'b0, 1'b1, d);
			chk("period", i == 4 ? 16'd96 : 16'd32 << (2 * i), 16'(c + d));
		end
		bus(1'b1, DIVISOR_OFFSET, 8'h00);
		txFrame(8'h00, 8'h20, 8'ha5);
		txFrame(8'h78, 8'h20, 8'h53);
		txFrame(8'h2c, 8'h24, 8'h3c);
		txFrame(8'h20, 8'h22, 8'h81);
		bus(1'b1, MODE_OFFSET, 8'he8);
		bus(1'b1, CONTROL_OFFSET, 8'h30);
		bus(1'b1, TXDATA_OFFSET, 8'hc6);
		for (int i = 0; i < 8; i++) begin
			waitPin(1'b0, 1'b0, c);
			waitPin(1'b0, 1'b1, c);
			chk("sync txd", (16'h00c6 >> i) & 16'h1, {15'h0, txd});
		end
		repeat (40) @(posedge ref_clk);
		chk("sync idle", 16'h1, {15'h0, sckOut});
		bus(1'b0, STATUS_OFFSET, 8'h00);
		chk("sync status", 16'h0001, q & 16'h003d);
		bus(1'b0, RXDATA_OFFSET, 8'h00);
		chk("sync rx data", 16'h00ff, q);
		bus(1'b1, MODE_OFFSET, 8'h00);
		bus(1'b1, CONTROL_OFFSET, 8'h10);
		bus(1'b1, STATUS_OFFSET, 8'hff);
		bus(1'b1, MASK_OFFSET, 8'h01);
		i_peer.sendFrame(12'hf2c, 10);
		i_peer.sendFrame(12'he22, 10);
		repeat (4) @(posedge ref_clk);
		chk("irq set", 16'h1, {15'h0, irq});
		bus(1'b0, STATUS_OFFSET, 8'h00);
		chk("overrun", 16'h0005, q & 16'h00fd);
		bus(1'b0, RXDATA_OFFSET, 8'h00);
		chk("rx data", 16'h0096, q);
		bus(1'b1, STATUS_OFFSET, 8'hff);
		@(negedge ref_clk);
		chk("irq clear", 16'h0, {15'h0, irq});
		i_peer.sendFrame(12'h000, 10);
		repeat (4) @(posedge ref_clk);
		bus(1'b0, STATUS_OFFSET, 8'h00);
		chk("break", 16'h0028, q & 16'h0028);
		tallyAndFinish();
	end
endmodule : tb_top
